// ---- rtl/ivd_pkg.sv ----
package ivd_pkg;

    // ------------------------------------------------------------
    // source indices, higher index wins arbitration
    // ------------------------------------------------------------
    localparam int SRC_N = 7;
    localparam int SRC_USB = 0;
    localparam int SRC_SCI = 1;
    localparam int SRC_TIM = 2;
    localparam int SRC_EXT = 3;
    localparam int SRC_SUSP = 4;
    localparam int SRC_FLASH = 5;
    localparam int SRC_TRAP = 6;
    localparam int EXT_N = 8;

    // ------------------------------------------------------------
    // vector table, top 32 bytes, two bytes per vector
    // ------------------------------------------------------------
    localparam logic [15:0] VEC_TABLE_BASE = 16'hffe0;
    localparam int VEC_TABLE_BYTES = 32;
    localparam logic [15:0] VEC_USB = 16'hffee;
    localparam logic [15:0] VEC_SCI = 16'hfff0;
    localparam logic [15:0] VEC_TIM = 16'hfff4;
    localparam logic [15:0] VEC_EXT = 16'hfff6;
    localparam logic [15:0] VEC_SUSP = 16'hfff8;
    localparam logic [15:0] VEC_FLASH = 16'hfffa;
    localparam logic [15:0] VEC_TRAP = 16'hfffc;
    localparam logic [15:0] VEC_RESET = 16'hfffe;
    localparam logic [SRC_N-1:0][15:0] VEC_TAB = {VEC_TRAP, VEC_FLASH,
        VEC_SUSP, VEC_EXT, VEC_TIM, VEC_SCI, VEC_USB};
    // reserved slots inside the table
    localparam logic [15:0] RSV_A_LO = 16'hffe0;
    localparam logic [15:0] RSV_A_HI = 16'hffed;
    localparam logic [15:0] RSV_B_LO = 16'hfff2;
    localparam logic [15:0] RSV_B_HI = 16'hfff3;

    // ------------------------------------------------------------
    // masking and halt wakeup per source
    // ------------------------------------------------------------
    localparam logic [SRC_N-1:0] SRC_UNMASKABLE = 7'h40;
    localparam logic [SRC_N-1:0] SRC_WAKE = 7'h38;

    // ------------------------------------------------------------
    // 64 Kbyte address space
    // ------------------------------------------------------------
    localparam logic [15:0] PERIPH_BASE = 16'h0000;
    localparam logic [15:0] PERIPH_TOP = 16'h003f;
    localparam logic [15:0] RAM_TOP = 16'h017f;
    localparam logic [15:0] STACK_BASE = 16'h0100;
    localparam logic [15:0] STACK_TOP = 16'h017f;
    localparam logic [15:0] PROG_BASE = 16'he000;

    // ------------------------------------------------------------
    // dispatch sequencer
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_HI = 2'b01,
        ST_LO = 2'b10,
        ST_END = 2'b11
    } ivd_state_e;

    localparam logic BOOT_RST = 1'b1;

endpackage : ivd_pkg

// ---- rtl/ivd_top.sv ----
`timescale 1ns/1ps
// Overview of operation
// - top 32 program bytes hold two-byte vectors
// - external lines share fff6, masked, wake halt
// - end of suspend at fff8, masked, wakes
// - flash start programming at fffa, masked, wakes
// - trap at fffc, never masked, no wake
// - one 64 Kbyte space for memories and registers
// - 64 peripheral bytes inside low 384 bytes
// - stack limited to 0100 through 017f
module ivd_top
    import ivd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    // bit 0 is ext_irq_line_first, bit 7 is ext_irq_line_last
    input wire logic [EXT_N-1:0] ext_irq_line,
    input wire logic usb_evt,
    input wire logic sci_evt,
    input wire logic tim_evt,
    input wire logic susp_end_evt,
    input wire logic flash_prog_evt,
    input wire logic trap_req,
    input wire logic int_mask,
    input wire logic halt_mode,
    output logic int_req,
    input wire logic int_ack,
    output logic fetch_en,
    output logic [15:0] fetch_addr,
    input wire logic [7:0] fetch_data,
    output logic [15:0] handler_addr,
    output logic handler_valid,
    output logic wake,
    input wire logic [15:0] map_addr,
    output logic map_periph,
    output logic map_ram,
    output logic map_stack,
    output logic map_prog,
    output logic map_reserved
);

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic [1:0] rst_sync_reg;
    logic rst_n;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [EXT_N-1:0] ext_s1;
        logic [EXT_N-1:0] ext_s2;
        logic [EXT_N-1:0] ext_s3;
        logic [SRC_N-1:0] pend;
        ivd_state_e state;
        logic boot;
        logic [15:0] vec;
        logic [7:0] hi;
        logic fetch_en;
        logic [15:0] fetch_addr;
        logic [15:0] handler;
        logic handler_valid;
        logic wake;
        logic periph;
        logic ram;
        logic stack;
        logic prog;
        logic rsv;
    } ivd_regs_s;

    ivd_regs_s st_reg;
    ivd_regs_s st_next;
    logic [SRC_N-1:0] events;
    logic [SRC_N-1:0] eligible;
    logic [SRC_N-1:0] grant;

    // ext lines are edge events seen after the synchroniser
    assign events = {trap_req, flash_prog_evt, susp_end_evt,
        |(st_reg.ext_s2 & ~st_reg.ext_s3), tim_evt, sci_evt, usb_evt};
    // masked sources drop out, trap stays eligible
    assign eligible = st_reg.pend & (int_mask ? SRC_UNMASKABLE
        : {SRC_N{1'b1}});

    always_comb begin
        grant = '0;
        for (int i = 0; i < SRC_N; i++) begin
            if (eligible[i]) begin
                grant = '0;
                grant[i] = 1'b1;
            end
        end
    end

    assign int_req = (st_reg.state == ST_IDLE) && !st_reg.boot
        && (|eligible);

    always_comb begin
        st_next = st_reg;
        st_next.ext_s1 = ext_irq_line;
        st_next.ext_s2 = st_reg.ext_s1;
        st_next.ext_s3 = st_reg.ext_s2;
        st_next.handler_valid = 1'b0;
        // a clear by grant loses to a new event in the same cycle
        if (int_ack && int_req) begin
            st_next.pend = st_reg.pend & ~grant;
        end
        st_next.pend = st_next.pend | events;
        case (st_reg.state)
            ST_IDLE: begin
                if (st_reg.boot) begin
                    st_next.boot = 1'b0;
                    st_next.vec = VEC_RESET;
                    st_next.state = ST_HI;
                    st_next.fetch_en = 1'b1;
                    st_next.fetch_addr = VEC_RESET;
                end else if (int_ack && int_req) begin
                    for (int i = 0; i < SRC_N; i++) begin
                        if (grant[i]) begin
                            st_next.vec = VEC_TAB[i];
                        end
                    end
                    st_next.state = ST_HI;
                    st_next.fetch_en = 1'b1;
                    st_next.fetch_addr = st_next.vec;
                end
            end
            ST_HI: begin
                st_next.fetch_addr = {st_reg.vec[15:1], 1'b1};
                st_next.state = ST_LO;
            end
            ST_LO: begin
                st_next.hi = fetch_data;
                st_next.fetch_en = 1'b0;
                st_next.state = ST_END;
            end
            ST_END: begin
                st_next.handler = {st_reg.hi, fetch_data};
                st_next.handler_valid = 1'b1;
                st_next.state = ST_IDLE;
            end
            default: begin
                st_next.state = ST_IDLE;
            end
        endcase
        // trap is not a wake source; masked sources cannot wake
        st_next.wake = halt_mode && (|(st_reg.pend & SRC_WAKE))
            && !int_mask;
        // address classification, registered for the core
        st_next.periph = map_addr <= PERIPH_TOP;
        st_next.ram = (map_addr > PERIPH_TOP) && (map_addr <= RAM_TOP);
        st_next.stack = (map_addr >= STACK_BASE)
            && (map_addr <= STACK_TOP);
        st_next.prog = map_addr >= PROG_BASE;
        // reserved slots and holes flagged; behaviour there is undefined
        st_next.rsv = ((map_addr >= RSV_A_LO) && (map_addr <= RSV_A_HI))
            || ((map_addr >= RSV_B_LO) && (map_addr <= RSV_B_HI))
            || ((map_addr > RAM_TOP) && (map_addr < PROG_BASE));
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
            st_reg.boot <= BOOT_RST;
            st_reg.state <= ST_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    assign fetch_en = st_reg.fetch_en;
    assign fetch_addr = st_reg.fetch_addr;
    assign handler_addr = st_reg.handler;
    assign handler_valid = st_reg.handler_valid;
    assign wake = st_reg.wake;
    assign map_periph = st_reg.periph;
    assign map_ram = st_reg.ram;
    assign map_stack = st_reg.stack;
    assign map_prog = st_reg.prog;
    assign map_reserved = st_reg.rsv;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    property p_vec_table;
        fetch_en |-> fetch_addr >= VEC_TABLE_BASE;
    endproperty
    a_vec_table: assert property (p_vec_table)
        else $error("fetch outside vector table");

    property p_ext_vec;
        int_ack && int_req && grant[SRC_EXT] |=> fetch_addr == VEC_EXT;
    endproperty
    a_ext_vec: assert property (p_ext_vec)
        else $error("external vector wrong");

    property p_susp_vec;
        int_ack && int_req && grant[SRC_SUSP] |=> fetch_addr == VEC_SUSP;
    endproperty
    a_susp_vec: assert property (p_susp_vec)
        else $error("suspend end vector wrong");

    property p_masked;
        int_mask && !st_reg.pend[SRC_TRAP] |-> !int_req;
    endproperty
    a_masked: assert property (p_masked)
        else $error("masked source requested");

    property p_trap;
        st_reg.state == ST_IDLE && !st_reg.boot && st_reg.pend[SRC_TRAP]
            && int_ack |=> fetch_en && fetch_addr == VEC_TRAP;
    endproperty
    a_trap: assert property (p_trap)
        else $error("trap not dispatched");

    property p_trap_no_wake;
        (st_reg.pend & SRC_WAKE) == '0 |=> !wake;
    endproperty
    a_trap_no_wake: assert property (p_trap_no_wake)
        else $error("wake without wake source");

    property p_wake;
        halt_mode && !int_mask && st_reg.pend[SRC_FLASH] |=> wake;
    endproperty
    a_wake: assert property (p_wake)
        else $error("flash event failed to wake");

    property p_stack;
        map_stack |-> $past(map_addr) >= STACK_BASE
            && $past(map_addr) <= STACK_TOP;
    endproperty
    a_stack: assert property (p_stack)
        else $error("stack decode wrong");

    property p_periph;
        map_periph |-> $past(map_addr) <= PERIPH_TOP && !map_ram;
    endproperty
    a_periph: assert property (p_periph)
        else $error("peripheral decode wrong");

    property p_pair;
        st_reg.state == ST_HI ##1 st_reg.state == ST_LO |->
            fetch_addr == ($past(fetch_addr) | 16'h0001) ##2
            handler_valid && handler_addr ==
            {$past(fetch_data, 2), $past(fetch_data)};
    endproperty
    a_pair: assert property (p_pair)
        else $error("handler byte pairing wrong");

    c_trap: cover property (st_reg.pend[SRC_TRAP] && int_mask && int_ack);
    c_ext: cover property (int_ack && int_req && grant[SRC_EXT]);
    c_wake: cover property (halt_mode ##1 wake);
    c_done: cover property (handler_valid);

endmodule : ivd_top

// ---- test/ivd_mem_model.sv ----
`timescale 1ns/1ps
module ivd_mem_model
(
    input wire logic clk_sys,
    input wire logic fetch_en,
    input wire logic [15:0] fetch_addr,
    output logic [7:0] fetch_data
);
    // ------------------------------------------------------------
    // vector image, one cycle read latency
    // ------------------------------------------------------------
    // byte = low address xor pattern, so hi and lo of a vector differ
    initial fetch_data = 8'h00;
    always @(posedge clk_sys) begin
        if (fetch_en) begin
            fetch_data <= fetch_addr[7:0] ^ 8'h3c;
        end else begin
            // idle bus toggles, a stale byte must never look valid
            fetch_data <= ~fetch_data;
        end
    end
endmodule : ivd_mem_model

// ---- test/ivd_top_tb.sv ----
`timescale 1ns/1ps
module ivd_top_tb;
    import ivd_pkg::*;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic [EXT_N-1:0] ext_irq_line = 8'h00;
    logic [SRC_N-1:0] src_p = 7'h00;
    logic int_mask = 1'b0;
    logic halt_mode = 1'b0;
    logic int_ack = 1'b0;
    logic [15:0] map_addr = 16'h0000;
    logic [7:0] fetch_data;
    logic int_req, fetch_en, handler_valid, wake;
    logic [15:0] fetch_addr, handler_addr;
    wire [4:0] map_v;
    logic [15:0] exp_q[$];
    logic [15:0] bnd [12] = '{16'h003f, 16'h0040, 16'h00ff, 16'h0100,
        16'h017f, 16'h0180, 16'hdfff, 16'he000, 16'hffe0, 16'hffed,
        16'hfff2, 16'hfff4};
    int errors = 0;
    int checked = 0;
    int cycles = 0;

    always #20 clk_sys = ~clk_sys;

    ivd_top i_dut (.clk_sys(clk_sys), .nrst(nrst),
        .ext_irq_line(ext_irq_line), .usb_evt(src_p[SRC_USB]),
        .sci_evt(src_p[SRC_SCI]), .tim_evt(src_p[SRC_TIM]),
        .susp_end_evt(src_p[SRC_SUSP]), .flash_prog_evt(src_p[SRC_FLASH]),
        .trap_req(src_p[SRC_TRAP]), .int_mask(int_mask),
        .halt_mode(halt_mode), .int_req(int_req), .int_ack(int_ack),
        .fetch_en(fetch_en), .fetch_addr(fetch_addr),
        .fetch_data(fetch_data), .handler_addr(handler_addr),
        .handler_valid(handler_valid), .wake(wake), .map_addr(map_addr),
        .map_periph(map_v[4]), .map_ram(map_v[3]), .map_stack(map_v[2]),
        .map_prog(map_v[1]), .map_reserved(map_v[0]));

    ivd_mem_model i_mem (.clk_sys(clk_sys), .fetch_en(fetch_en),
        .fetch_addr(fetch_addr), .fetch_data(fetch_data));

    // ------------------------------------------------------------
    // checking and closing
    // ------------------------------------------------------------
    task automatic cmp_handler(logic [15:0] e, logic [15:0] g);
        checked++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] handler_addr expected %h seen %h", e, g);
        end
    endtask : cmp_handler

    task automatic cmp_flag(string what, logic e, logic g);
        checked++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %b seen %b", what, e, g);
        end
    endtask : cmp_flag

    // flags in order periph, ram, stack, prog, reserved
    task automatic cmp_map(logic [15:0] a, logic [4:0] e, logic [4:0] g);
        checked++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] map flags at %h expected %b seen %b", a, e, g);
        end
    endtask : cmp_map

    task automatic conclude();
        cmp_flag("pending notes empty", 1'b1, exp_q.size() == 0);
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude

    function automatic logic [15:0] hexp(logic [15:0] v);
        return {v[7:0] ^ 8'h3c, (v[7:0] | 8'h01) ^ 8'h3c};
    endfunction : hexp

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles > 5000) begin
            errors++;
            conclude();
        end else if (nrst && handler_valid !== 1'b0) begin
            if (exp_q.size() == 0) begin
                cmp_flag("spurious valid", 1'b0, handler_valid);
            end else begin
                cmp_handler(exp_q.pop_front(), handler_addr);
            end
        end
    end

    // ------------------------------------------------------------
    // stimulus tasks
    // ------------------------------------------------------------
    task automatic fire(logic [SRC_N-1:0] m);
        @(posedge clk_sys);
        src_p <= m & ~(7'h01 << SRC_EXT);
        // ext pin stays high until the grant, an async line may be slow
        if (m[SRC_EXT]) begin
            ext_irq_line <= 8'h01 << $urandom_range(7, 0);
        end
        @(posedge clk_sys);
        src_p <= 7'h00;
    endtask : fire

    task automatic take(logic [15:0] v);
        int n;
        n = 0;
        exp_q.push_back(hexp(v));
        do begin
            @(negedge clk_sys);
            n++;
        end while (int_req !== 1'b1 && n < 30);
        cmp_flag("int_req", 1'b1, int_req);
        @(posedge clk_sys);
        int_ack <= 1'b1;
        @(posedge clk_sys);
        int_ack <= 1'b0;
        ext_irq_line <= 8'h00;
        repeat (6) @(posedge clk_sys);
    endtask : take

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [15:0] a;
        logic [4:0] e;
        void'($urandom(32'hcbf5bb8a));
        exp_q.push_back(hexp(VEC_RESET));
        repeat (6) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (12) @(posedge clk_sys);
        $display("test boot done");
        for (int s = 0; s < SRC_N; s++) begin
            fire(7'h01 << s);
            take(VEC_TAB[s]);
        end
        $display("test vectors done");
        fire((7'h01 << SRC_FLASH) | (7'h01 << SRC_USB));
        take(VEC_FLASH);
        take(VEC_USB);
        $display("test priority done");
        int_mask <= 1'b1;
        fire(7'h01 << SRC_SUSP);
        repeat (6) @(negedge clk_sys);
        cmp_flag("masked int_req", 1'b0, int_req);
        fire(7'h01 << SRC_TRAP);
        take(VEC_TRAP);
        int_mask <= 1'b0;
        take(VEC_SUSP);
        $display("test mask done");
        halt_mode <= 1'b1;
        for (int s = SRC_EXT; s <= SRC_FLASH; s++) begin
            fire(7'h01 << s);
            repeat (6) @(negedge clk_sys);
            cmp_flag("wake", 1'b1, wake);
            take(VEC_TAB[s]);
        end
        // trap left pending long enough to reach wake if it counted
        fire(7'h01 << SRC_TRAP);
        repeat (3) @(negedge clk_sys);
        cmp_flag("trap wake", 1'b0, wake);
        take(VEC_TRAP);
        int_mask <= 1'b1;
        fire(7'h01 << SRC_FLASH);
        repeat (3) @(negedge clk_sys);
        cmp_flag("masked wake", 1'b0, wake);
        @(posedge clk_sys);
        int_mask <= 1'b0;
        take(VEC_FLASH);
        halt_mode <= 1'b0;
        $display("test wake done");
        for (int i = 0; i < 44; i++) begin
            a = (i < 12) ? bnd[i] : 16'($urandom);
            @(posedge clk_sys);
            map_addr <= a;
            @(posedge clk_sys);
            @(negedge clk_sys);
            e[4] = a <= PERIPH_TOP;
            e[3] = a >= 16'h0040 && a <= RAM_TOP;
            e[2] = a >= STACK_BASE && a <= STACK_TOP;
            e[1] = a >= PROG_BASE;
            e[0] = (a >= 16'h0180 && a < PROG_BASE)
                || (a >= RSV_A_LO && a <= RSV_A_HI)
                || (a >= RSV_B_LO && a <= RSV_B_HI);
            cmp_map(a, e, map_v);
        end
        $display("test map done");
        conclude();
    end
endmodule : ivd_top_tb
